// File: rtl/dgr_pkg.sv
// Shared constants of the digitizer register bank and its host bridge
package dgr_pkg;
  // ************************************************
  // Address formation
  // ************************************************
  localparam logic [31:0] DGR_FUNC_OFS   = 32'h00C00000;
  localparam logic [7:0]  DGR_OFS_GLOBAL = 8'h00;
  localparam logic [7:0]  DGR_OFS_FORCE  = 8'h02;
  localparam logic [7:0]  DGR_OFS_RSVD   = 8'h04;
  localparam logic [7:0]  DGR_OFS_EXTLVL = 8'h06;
  localparam logic [7:0]  DGR_CH0_OFS    = 8'h08;
  localparam logic [7:0]  DGR_CH_STRIDE  = 8'h28;
  localparam int          DGR_CH_NUM     = 6;
  // ************************************************
  // Global fields
  // ************************************************
  localparam logic [15:0] DGR_GLB_MASK   = 16'h4007;
  localparam logic [15:0] DGR_EXT_MASK   = 16'h0FFF;
  localparam int          DGR_FAIL_BIT   = 14;
  localparam int          DGR_FSRC_LSB   = 13;
  localparam int          DGR_EDGE_BIT   = 12;
  localparam int          DGR_FTRIG_LSB  = 6;
  localparam logic [2:0]  DGR_FSRC_EXT   = 3'h6;
  localparam logic [2:0]  DGR_FSRC_MAXCH = 3'h3;
  // ************************************************
  // Channel words (index = byte offset in channel / 2)
  // ************************************************
  localparam int          DGR_RW_WORDS   = 14;
  localparam logic [4:0]  DGR_W_CTRL     = 5'h00;
  localparam logic [4:0]  DGR_W_IEN      = 5'h0B;
  localparam logic [4:0]  DGR_W_STAT     = 5'h0C;
  localparam logic [4:0]  DGR_W_FIFO     = 5'h0E;
  localparam logic [4:0]  DGR_W_RES      = 5'h10;
  localparam logic [4:0]  DGR_W_LAST     = 5'h13;
  localparam logic [15:0] DGR_WMASK [DGR_RW_WORDS] = '{
    16'h3FFF, 16'h0FFF, 16'h01FF, 16'hFFFF, 16'h000F, 16'hFFFF, 16'h000F,
    16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'h0000};
  localparam logic [19:0] DGR_PAIR_MAP   = 20'h54154;
  localparam int          DGR_COUPLE_BIT = 13;
  localparam int          DGR_OHM_BIT    = 12;
  localparam int          DGR_TMO_EN_BIT = 11;
  localparam logic [15:0] DGR_STAT_MASK  = 16'h9FFF;
  localparam logic [63:0] DGR_RES_INIT   = 64'h3FBF9ADD3746F4C6;
  // ************************************************
  // Host bridge registers (APB byte offsets)
  // ************************************************
  localparam logic [7:0]  DGR_H_ADDR     = 8'h00;
  localparam logic [7:0]  DGR_H_WDATA    = 8'h04;
  localparam logic [7:0]  DGR_H_CTRL     = 8'h08;
  localparam logic [7:0]  DGR_H_STAT     = 8'h0C;
  localparam logic [7:0]  DGR_H_RDATA    = 8'h10;
  localparam int          DGR_HC_GO      = 0;
  localparam int          DGR_HC_WRITE   = 1;
  localparam int          DGR_HC_WIDE    = 2;
  localparam int          DGR_H_TMO_CYC  = 256;
endpackage

// File: rtl/dgr_link_if.sv
// Register link between host bridge and digitizer register bank
`timescale 1ns/100ps
`default_nettype none
interface dgr_link_if;
  logic        req;
  logic        we;
  logic        wide;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic        berr;
  modport dev  (input req, we, wide, addr, wdata, output rdata, ack, berr);
  modport host (output req, we, wide, addr, wdata, input rdata, ack, berr);
endinterface
`default_nettype wire

// File: rtl/dgr_chan_regs.sv
// Per-channel register words of the digitizer register bank
`timescale 1ns/100ps
`default_nettype none
module dgr_chan_regs
  import dgr_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        we_i,
  input  wire logic        wide_i,
  input  wire logic [4:0]  idx_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic [31:0] fifo_i,
  input  wire logic        res_ld_i,
  input  wire logic [63:0] res_i,
  input  wire logic [15:1] event_i,
  input  wire logic        tmo_i,
  output logic      [31:0] rdata_o,
  output logic             pair_ok_o,
  output logic      [15:0] ctrl_o,
  output logic             irq_o
);
  logic [15:0] mem_r [DGR_RW_WORDS];
  logic [63:0] res_r;
  logic [15:0] stat;

  function automatic logic [15:0] word(input logic [4:0] i);
    // Status sits inside the stored range, so it must be picked first
    if (i == DGR_W_STAT)           word = stat;
    else if (i < 5'(DGR_RW_WORDS)) word = mem_r[i[3:0]];
    else if (i == DGR_W_FIFO)      word = fifo_i[31:16];
    else if (i == DGR_W_FIFO + 5'h01) word = fifo_i[15:0];
    else if (i >= DGR_W_RES && i <= DGR_W_LAST)
      word = res_r[6'(63 - 16 * int'(i - DGR_W_RES)) -: 16];
    else                           word = 16'h0000;
  endfunction

  // Timeout flag only when enabled in control
  assign stat = {event_i, tmo_i & mem_r[0][DGR_TMO_EN_BIT]} & DGR_STAT_MASK;
  assign ctrl_o = mem_r[0];
  assign pair_ok_o = DGR_PAIR_MAP[idx_i];

  // Upper half on high lanes, lower on low lanes
  always_comb begin
    if (wide_i) begin
      rdata_o = {word(idx_i), word(idx_i + 5'h01)};
    end else begin
      rdata_o = {16'h0000, word(idx_i)};
    end
  end

  // Unused bits masked, read zero
  always_ff @(posedge clk_sys_i) begin
    for (int w = 0; w < DGR_RW_WORDS; w++) begin
      if (sys_rst_i) begin
        mem_r[w] <= 16'h0000;
      end else if (we_i && idx_i == 5'(w)) begin
        mem_r[w] <= (wide_i ? wdata_i[31:16] : wdata_i[15:0]) & DGR_WMASK[w];
      end else if (we_i && wide_i && idx_i + 5'h01 == 5'(w)) begin
        mem_r[w] <= wdata_i[15:0] & DGR_WMASK[w];
      end
    end
  end

  // Byte-order pattern at power-up
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      res_r <= DGR_RES_INIT;
    end else if (res_ld_i) begin
      res_r <= res_i;
    end
  end

  // Status raises interrupt only where enabled
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(stat & mem_r[DGR_W_IEN[3:0]]);
    end
  end
endmodule
`default_nettype wire

// File: rtl/dgr_dev_end.sv
// Digitizer global register bank: link slave, global controls, six channels
// Operation
// - 32-bit read: upper half high, lower low
// - 32-bit write: high lanes upper, low lower
// - Host uses 16-bit access outside pairs
// - Result words preloaded with byte-order pattern
// - Decode base byte plus function offset
// - 16/32-bit accepted; 32-bit only on pairs
// - Wide access to single register gets error
// - Channel blocks repeat every 0x28 from 0x08
// - Global bit 14 masks system-fail output
// - Bits 2..0 select interrupt level, 0 off
// - Fast trigger source: channels 0-3, external
// - Bit 12 selects external trigger edge
// - Bits 11..6 force-trigger armed channels
// - Only 0-to-1 force transition triggers
// - Bits 5..0 arm channels 0..5
// - Clearing arm resets channel acquisition
// - 12-bit external trigger threshold at 0x06
// - Control bit 13 selects fast-channel coupling
// - Control bit 12 selects fast-channel impedance
// - Control bit 11 gates timeout status flag
// - Status interrupts only where enabled
`timescale 1ns/100ps
`default_nettype none
module dgr_dev_end (
  input  wire logic                                   clk_sys_i,
  input  wire logic                                   sys_rst_i,
  dgr_link_if.dev                                     link,
  input  wire logic [7:0]                             base_sw_i,
  input  wire logic                                   fail_i,
  input  wire logic [dgr_pkg::DGR_CH_NUM-1:0][31:0]   fifo_i,
  input  wire logic [dgr_pkg::DGR_CH_NUM-1:0]         res_ld_i,
  input  wire logic [63:0]                            res_i,
  input  wire logic [dgr_pkg::DGR_CH_NUM-1:0][15:1]   event_i,
  input  wire logic [dgr_pkg::DGR_CH_NUM-1:0]         tmo_i,
  output logic                                        sysfail_o,
  output logic                                        irq_req_o,
  output logic      [2:0]                             irq_level_o,
  output logic      [2:0]                             fast_trigger_source_o,
  output logic                                        fast_src_valid_o,
  output logic                                        external_edge_polarity_o,
  output logic      [11:0]                            ext_threshold_o,
  output logic      [dgr_pkg::DGR_CH_NUM-1:0]         arm_bits_o,
  output logic      [dgr_pkg::DGR_CH_NUM-1:0]         soft_trig_o,
  output logic      [dgr_pkg::DGR_CH_NUM-1:0]         acq_reset_o,
  output logic      [dgr_pkg::DGR_CH_NUM-1:0][15:0]   chan_ctrl_o,
  output logic      [1:0]                             dc_couple_o,
  output logic      [1:0]                             ohm50_o
);
  import dgr_pkg::*;

  // ************************************************
  // Storage
  // ************************************************
  logic [15:0]            glb_r;
  logic [15:0]            force_r;
  logic [15:0]            ext_r;
  logic [DGR_CH_NUM-1:0]  ftrig_prev_r;
  logic [DGR_CH_NUM-1:0]  arm_prev_r;
  logic [31:0]            rdata_r;
  logic                   ack_r;
  logic                   berr_r;

  logic [7:0]             off;
  logic                   hit;
  logic                   take;
  logic                   bad;
  logic                   wr_ok;
  logic [DGR_CH_NUM-1:0]  ch_hit;
  logic [4:0]             idx;
  logic                   pair_ok;
  logic [31:0]            rd_val;
  logic [DGR_CH_NUM-1:0]  ch_irq;
  logic [DGR_CH_NUM-1:0]  ch_pair;
  logic [31:0]            ch_rd [DGR_CH_NUM];
  logic [15:0]            ch_ctrl [DGR_CH_NUM];
  logic [DGR_CH_NUM-1:0]  ftrig;

  function automatic logic [7:0] ch_base(input int c);
    ch_base = 8'(int'(DGR_CH0_OFS) + c * int'(DGR_CH_STRIDE));
  endfunction

  // ************************************************
  // Address decode
  // ************************************************
  always_comb begin
    off = link.addr[7:0];
    hit = (link.addr[31:24] == base_sw_i) && (link.addr[23:8] == DGR_FUNC_OFS[23:8]);
    ch_hit = '0;
    idx = 5'h00;
    pair_ok = 1'b0;
    rd_val = 32'h0000_0000;
    for (int c = 0; c < DGR_CH_NUM; c++) begin
      if (off >= ch_base(c) && off < ch_base(c) + DGR_CH_STRIDE) begin
        ch_hit[c] = 1'b1;
        idx = 5'((off - ch_base(c)) >> 1);
        pair_ok = ch_pair[c];
        rd_val = ch_rd[c];
      end
    end
    if (ch_hit == '0) begin
      case (off)
        DGR_OFS_GLOBAL: rd_val = {16'h0000, glb_r};
        DGR_OFS_FORCE:  rd_val = {16'h0000, force_r};
        DGR_OFS_EXTLVL: rd_val = {16'h0000, ext_r};
        default:        rd_val = 32'h0000_0000;
      endcase
    end
  end

  // Misaligned, or wide outside a pair: refused
  assign bad   = link.addr[0] | (link.wide & ~pair_ok);
  assign take  = link.req & hit & ~ack_r & ~berr_r;
  assign wr_ok = take & ~bad & link.we;

  // ************************************************
  // Link answer
  // ************************************************
  // Foreign base addresses get no answer, as on a shared bus
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ack_r   <= 1'b0;
      berr_r  <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r  <= take & ~bad;
      berr_r <= take & bad;
      if (take && !bad && !link.we) begin
        rdata_r <= rd_val;
      end
    end
  end

  assign link.ack   = ack_r;
  assign link.berr  = berr_r;
  assign link.rdata = rdata_r;

  // ************************************************
  // Global registers
  // ************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      glb_r   <= 16'h0000;
      force_r <= 16'h0000;
      ext_r   <= 16'h0000;
    end else if (wr_ok && ch_hit == '0) begin
      case (off)
        DGR_OFS_GLOBAL: glb_r   <= link.wdata[15:0] & DGR_GLB_MASK;
        DGR_OFS_FORCE:  force_r <= link.wdata[15:0];
        DGR_OFS_EXTLVL: ext_r   <= link.wdata[15:0] & DGR_EXT_MASK;
        default:        ;
      endcase
    end
  end

  // ************************************************
  // Channels
  // ************************************************
  for (genvar c = 0; c < DGR_CH_NUM; c++) begin : g_ch
    dgr_chan_regs u_chan (
      .clk_sys_i (clk_sys_i),
      .sys_rst_i (sys_rst_i),
      .we_i      (wr_ok & ch_hit[c]),
      .wide_i    (link.wide),
      .idx_i     (idx),
      .wdata_i   (link.wdata),
      .fifo_i    (fifo_i[c]),
      .res_ld_i  (res_ld_i[c]),
      .res_i     (res_i),
      .event_i   (event_i[c]),
      .tmo_i     (tmo_i[c]),
      .rdata_o   (ch_rd[c]),
      .pair_ok_o (ch_pair[c]),
      .ctrl_o    (ch_ctrl[c]),
      .irq_o     (ch_irq[c])
    );
    assign chan_ctrl_o[c] = ch_ctrl[c];
  end

  // Only fast channels 4 and 5 use coupling and impedance
  assign dc_couple_o = {ch_ctrl[5][DGR_COUPLE_BIT], ch_ctrl[4][DGR_COUPLE_BIT]};
  assign ohm50_o     = {ch_ctrl[5][DGR_OHM_BIT], ch_ctrl[4][DGR_OHM_BIT]};

  // ************************************************
  // Trigger and arm control
  // ************************************************
  assign ftrig                    = force_r[DGR_FTRIG_LSB +: DGR_CH_NUM];
  assign arm_bits_o               = force_r[DGR_CH_NUM-1:0];
  assign fast_trigger_source_o    = force_r[DGR_FSRC_LSB +: 3];
  assign external_edge_polarity_o = force_r[DGR_EDGE_BIT];
  assign ext_threshold_o          = ext_r[11:0];

  // A held force bit fires once; host must write it back to 0 first
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      ftrig_prev_r <= '0;
      arm_prev_r   <= '0;
      soft_trig_o  <= '0;
      acq_reset_o  <= '0;
    end else begin
      ftrig_prev_r <= ftrig;
      arm_prev_r   <= arm_bits_o;
      soft_trig_o  <= ftrig & ~ftrig_prev_r & arm_bits_o;
      acq_reset_o  <= arm_prev_r & ~arm_bits_o;
    end
  end

  // Invalid codes 100, 101, 111 flagged rather than remapped
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fast_src_valid_o <= 1'b1;
    end else begin
      fast_src_valid_o <= (force_r[DGR_FSRC_LSB +: 3] <= DGR_FSRC_MAXCH)
                       || (force_r[DGR_FSRC_LSB +: 3] == DGR_FSRC_EXT);
    end
  end

  // ************************************************
  // System fail and interrupt request
  // ************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      sysfail_o   <= 1'b0;
      irq_req_o   <= 1'b0;
      irq_level_o <= 3'h0;
    end else begin
      sysfail_o   <= fail_i & ~glb_r[DGR_FAIL_BIT];
      irq_level_o <= glb_r[2:0];
      irq_req_o   <= (|ch_irq) && (glb_r[2:0] != 3'h0);
    end
  end
endmodule
`default_nettype wire

// File: rtl/dgr_host_end.sv
// Host bridge: APB command registers driving the register link
`timescale 1ns/100ps
`default_nettype none
module dgr_host_end #(
  parameter int TMO_CYC = dgr_pkg::DGR_H_TMO_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  dgr_link_if.host         link
);
  import dgr_pkg::*;

  typedef enum logic {DGR_IDLE, DGR_WAIT} dgr_state_t;

  dgr_state_t  state_r;
  logic [31:0] addr_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic        req_r;
  logic        we_r;
  logic        wide_r;
  logic        done_r;
  logic        berr_r;
  logic        tmo_r;
  logic [15:0] cnt_r;
  logic        apb_wr;
  logic        go;
  logic        mapped;

  assign apb_wr = psel_i & penable_i & pready_o & pwrite_i;
  assign go     = apb_wr && paddr_i == DGR_H_CTRL && pwdata_i[DGR_HC_GO] && state_r == DGR_IDLE;
  assign mapped = paddr_i inside {DGR_H_ADDR, DGR_H_WDATA, DGR_H_CTRL, DGR_H_STAT, DGR_H_RDATA};

  // ************************************************
  // APB slave: one wait-free access cycle
  // ************************************************
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h0000_0000;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~mapped;
      case (paddr_i)
        DGR_H_ADDR:  prdata_o <= addr_r;
        DGR_H_WDATA: prdata_o <= wdata_r;
        DGR_H_CTRL:  prdata_o <= {29'h0, wide_r, we_r, req_r};
        DGR_H_STAT:  prdata_o <= {28'h0, tmo_r, berr_r, done_r, state_r == DGR_WAIT};
        DGR_H_RDATA: prdata_o <= rdata_r;
        default:     prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Address and data are frozen while a transfer is open
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      addr_r  <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
    end else if (apb_wr && state_r == DGR_IDLE) begin
      if (paddr_i == DGR_H_ADDR) addr_r <= pwdata_i;
      if (paddr_i == DGR_H_WDATA) wdata_r <= pwdata_i;
    end
  end

  // ************************************************
  // Link master
  // ************************************************
  // Host must pick wide only for pair addresses
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_r <= DGR_IDLE;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      wide_r  <= 1'b0;
      done_r  <= 1'b0;
      berr_r  <= 1'b0;
      tmo_r   <= 1'b0;
      cnt_r   <= 16'h0000;
      rdata_r <= 32'h0000_0000;
    end else begin
      case (state_r)
        DGR_IDLE: begin
          if (go) begin
            state_r <= DGR_WAIT;
            req_r   <= 1'b1;
            we_r    <= pwdata_i[DGR_HC_WRITE];
            wide_r  <= pwdata_i[DGR_HC_WIDE];
            done_r  <= 1'b0;
            berr_r  <= 1'b0;
            tmo_r   <= 1'b0;
            cnt_r   <= 16'h0000;
          end
        end
        DGR_WAIT: begin
          cnt_r <= cnt_r + 16'h0001;
          if (link.ack || link.berr) begin
            state_r <= DGR_IDLE;
            req_r   <= 1'b0;
            done_r  <= 1'b1;
            berr_r  <= link.berr;
            if (link.ack && !we_r) rdata_r <= link.rdata;
          end else if (cnt_r == 16'(TMO_CYC - 1)) begin
            // Nobody answered: base switches or function offset differ from the address
            state_r <= DGR_IDLE;
            req_r   <= 1'b0;
            done_r  <= 1'b1;
            tmo_r   <= 1'b1;
          end
        end
        default: state_r <= DGR_IDLE;
      endcase
    end
  end

  assign link.req   = req_r;
  assign link.we    = we_r;
  assign link.wide  = wide_r;
  assign link.addr  = addr_r;
  assign link.wdata = wdata_r;
endmodule
`default_nettype wire

// File: test/dgr_link_chk.sv
// Protocol checker for the link between host bridge and register bank
`timescale 1ns/100ps
`default_nettype none
module dgr_link_chk (
  input wire logic        clk_sys_i,
  input wire logic        sys_rst_i,
  input wire logic        req,
  input wire logic        we,
  input wire logic        wide,
  input wire logic [31:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic        ack,
  input wire logic        berr
);
  // ************************************************
  // Link answer rules
  // ************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  AST_ACK_PULSE: assert property (ack |=> !ack)
    else $error("ack held past one cycle");
  AST_BERR_PULSE: assert property (berr |=> !berr)
    else $error("berr held past one cycle");
  AST_ONE_ANSWER: assert property (!(ack && berr))
    else $error("ack and berr together");
  AST_ACK_FUNC_OFS: assert property (ack |-> $past(req) && $past(addr[23:8]) == 16'hC000)
    else $error("ack outside the function window");
  AST_ODD_REFUSED: assert property (ack |-> !$past(addr[0]))
    else $error("odd address acknowledged");
  AST_WIDE_GLOBAL: assert property (ack && $past(wide) |-> $past(addr[7:0]) >= 8'h08)
    else $error("wide access to global word acknowledged");
  AST_WRITE_KEEPS_RDATA: assert property (ack && we |-> $stable(rdata))
    else $error("read data moved on a write");
  AST_REQ_DROPS: assert property ((ack || berr) |=> !req)
    else $error("request kept after answer");
  AST_RST_QUIET: assert property ($fell(sys_rst_i) |-> !ack && !berr)
    else $error("answer during reset");
endmodule
`default_nettype wire

// File: test/digitizer_global_register_bank_bench.sv
// Self-checking bench: host bridge and register bank joined by the link
`timescale 1ns/100ps
`default_nettype none
module digitizer_global_register_bank_bench;
  import dgr_pkg::*;
  logic                          clk_sys_i = 0, sys_rst_i = 1, fail_i = 1;
  logic                          psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [7:0]                    paddr_i = 0, bs = 8'h19, base_sw_i = 8'h19;
  logic [31:0]                   pwdata_i = 0, prdata_o, rd, d;
  logic                          pready_o, sysfail_o, irq_req_o, fast_src_valid_o;
  logic                          pslverr_o, se;
  logic                          external_edge_polarity_o;
  logic [2:0]                    irq_level_o, fast_trigger_source_o;
  logic [11:0]                   ext_threshold_o;
  logic [DGR_CH_NUM-1:0]         arm_bits_o, soft_trig_o, acq_reset_o, tseen, rseen;
  logic [DGR_CH_NUM-1:0]         res_ld_i = 0, tmo_i = 0;
  logic [DGR_CH_NUM-1:0][31:0]   fifo_i;
  logic [DGR_CH_NUM-1:0][15:1]   event_i = 0;
  logic [DGR_CH_NUM-1:0][15:0]   chan_ctrl_o;
  logic [63:0]                   res_i = 0;
  logic [1:0]                    dc_couple_o, ohm50_o;
  logic [34:0]                   nq[$];
  logic [34:0]                   n;
  integer                        seed = 32'hF500;
  int                            error_cnt = 0, num_checks = 0;
  dgr_link_if lnk ();
  dgr_host_end #(.TMO_CYC(16)) i_dgr_host_end (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i,
    .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .link(lnk));
  dgr_dev_end i_dgr_dev_end (.clk_sys_i, .sys_rst_i, .link(lnk), .base_sw_i, .fail_i, .fifo_i,
    .res_ld_i, .res_i, .event_i, .tmo_i, .sysfail_o, .irq_req_o, .irq_level_o,
    .fast_trigger_source_o, .fast_src_valid_o, .external_edge_polarity_o, .ext_threshold_o,
    .arm_bits_o, .soft_trig_o, .acq_reset_o, .chan_ctrl_o, .dc_couple_o, .ohm50_o);
  dgr_link_chk i_dgr_link_chk (.clk_sys_i, .sys_rst_i, .req(lnk.req), .we(lnk.we),
    .wide(lnk.wide), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack),
    .berr(lnk.berr));
  always #2 clk_sys_i = ~clk_sys_i;
  // ************************************************
  // Helpers
  // ************************************************
  task ck(input logic [31:0] g, input logic [31:0] e, input string nm);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] dw);
    @(posedge clk_sys_i);
    psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= dw;
    @(posedge clk_sys_i);
    penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    se = pslverr_o;
    psel_i <= 0; penable_i <= 0;
  endtask
  // Mode 0 write or refusal, 1 narrow read, 2 wide read, 3 no answer at all
  task lk(input logic [7:0] o, input logic w, wd, input logic [31:0] dw,
          input logic [1:0] m, input logic eb, input logic [31:0] e);
    if (m != 2'd3) nq.push_back({m, eb, e});
    apb(1, DGR_H_ADDR, {bs, 24'hC00000} | {24'h0, o});
    apb(1, DGR_H_WDATA, dw);
    apb(1, DGR_H_CTRL, {29'h0, wd, w, 1'b1});
    repeat (40) begin
      apb(0, DGR_H_STAT, 0);
      if (rd[3:1] != 0) break;
    end
  endtask
  // Every link answer is matched against the oldest note
  always @(negedge clk_sys_i) if (lnk.ack || lnk.berr) begin
    n = nq.pop_front();
    ck(lnk.berr, n[32], "berr");
    ck(lnk.rdata & (n[34] ? 32'hFFFFFFFF : n[33] ? 32'h0000FFFF : 32'h0),
       n[31:0], "rdata");
  end
  always @(posedge clk_sys_i) begin
    tseen |= soft_trig_o;
    rseen |= acq_reset_o;
  end
  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    wrap_up();
  end
  // ************************************************
  // Scenarios
  // ************************************************
  initial begin
    for (int i = 0; i < DGR_CH_NUM; i++) fifo_i[i] = $random(seed);
    repeat (12) @(posedge clk_sys_i);
    sys_rst_i <= 0;
    ck({fast_src_valid_o, arm_bits_o, irq_level_o}, 32'h200, "reset outputs");
    for (int c = 0; c < DGR_CH_NUM; c++)
      for (int k = 0; k < 4; k++)
        lk(8'(8'h28 + c * 8'h28 + k * 2), 0, 0, 0, 1, 0,
           32'(16'(64'h3FBF9ADD3746F4C6 >> (48 - 16 * k))));
    lk(8'h28, 0, 1, 0, 2, 0, 32'h3FBF9ADD);
    lk(8'h2C, 0, 1, 0, 2, 0, 32'h3746F4C6);
    lk(8'h24, 0, 1, 0, 2, 0, fifo_i[0]);
    d = $random(seed);
    lk(8'h5C, 1, 1, d, 0, 0, 0);
    lk(8'h5C, 0, 0, 0, 1, 0, {16'h0, d[31:16] & 16'h01FF});
    lk(8'h5E, 0, 0, 0, 1, 0, {16'h0, d[15:0]});
    lk(8'h00, 0, 1, 0, 0, 1, 0);
    lk(8'h08, 1, 1, d, 0, 1, 0);
    lk(8'h03, 0, 0, 0, 0, 1, 0);
    lk(8'h26, 0, 1, 0, 0, 1, 0);
    bs = 8'h18;
    lk(8'h00, 0, 0, 0, 3, 0, 0);
    ck(rd[3], 1, "no answer off base");
    bs = 8'h19;
    ck(se, 0, "pslverr mapped");
    apb(0, 8'h14, 0);
    ck(se, 1, "pslverr unmapped");
    ck(rd, 0, "unmapped read");
    $display("test map done");
    lk(8'h00, 1, 0, 32'hFFFF, 0, 0, 0);
    lk(8'h00, 0, 0, 0, 1, 0, 32'h4007);
    ck(sysfail_o, 0, "fail masked");
    for (int l = 0; l < 8; l++) begin
      lk(8'h00, 1, 0, l, 0, 0, 0);
      ck(irq_level_o, l, "irq level");
    end
    ck(sysfail_o, 1, "fail passed");
    for (int s = 0; s < 8; s++) begin
      lk(8'h02, 1, 0, {16'h0, s[2:0], s[0], 12'h0}, 0, 0, 0);
      ck(fast_trigger_source_o, s, "fast source");
      ck(fast_src_valid_o, s < 4 || s == 6, "source valid");
      ck(external_edge_polarity_o, s[0], "edge");
    end
    $display("test global done");
    lk(8'h02, 1, 0, 32'h3F, 0, 0, 0);
    ck(arm_bits_o, 6'h3F, "arm");
    tseen = 0;
    lk(8'h02, 1, 0, 32'h0FFF, 0, 0, 0);
    ck(tseen, 6'h3F, "forced");
    tseen = 0;
    lk(8'h02, 1, 0, 32'h0FFF, 0, 0, 0);
    ck(tseen, 0, "no retrigger");
    lk(8'h02, 1, 0, 32'h003F, 0, 0, 0);
    tseen = 0;
    lk(8'h02, 1, 0, 32'h0FFF, 0, 0, 0);
    ck(tseen, 6'h3F, "retrigger after clear");
    rseen = 0;
    lk(8'h02, 1, 0, 32'h0FC0, 0, 0, 0);
    ck(rseen, 6'h3F, "disarm reset");
    lk(8'h06, 1, 0, 32'hFFFF, 0, 0, 0);
    lk(8'h06, 0, 0, 0, 1, 0, 32'h0FFF);
    ck(ext_threshold_o, 12'hFFF, "threshold");
    lk(8'h04, 1, 0, 32'hFFFF, 0, 0, 0);
    lk(8'h04, 0, 0, 0, 1, 0, 0);
    $display("test force done");
    lk(8'hA8, 1, 0, 32'h3000, 0, 0, 0);
    lk(8'hD0, 1, 0, 32'h2000, 0, 0, 0);
    ck(dc_couple_o, 2'b11, "coupling");
    ck(ohm50_o, 2'b01, "impedance");
    lk(8'hD0, 0, 0, 0, 1, 0, 32'h2000);
    ck(chan_ctrl_o[5], 16'h2000, "ch5 control");
    tmo_i <= 6'h01;
    lk(8'h08, 1, 0, 32'h0800, 0, 0, 0);
    lk(8'h20, 0, 0, 0, 1, 0, 32'h0001);
    lk(8'h1E, 1, 0, 32'h0001, 0, 0, 0);
    ck(irq_req_o, 1, "irq enabled");
    lk(8'h1E, 1, 0, 32'h0, 0, 0, 0);
    ck(irq_req_o, 0, "irq disabled");
    lk(8'h08, 1, 0, 32'h0, 0, 0, 0);
    lk(8'h20, 0, 0, 0, 1, 0, 32'h0);
    $display("test channel done");
    wrap_up();
  end
endmodule
`default_nettype wire
